// ==== shared/fault_timer_params.svh ====
`ifndef FAULT_TIMER_PARAMS_SVH
`define FAULT_TIMER_PARAMS_SVH

// Register offsets
`define DETECT_CLASS_OFS    8'h14
`define TIMING_CFG_OFS      8'h16
`define PORT_RESET_OFS      8'h1a
`define PORT_MODE_OFS       8'h12
`define FOLDBACK_OFS        8'h40
`define FAULT_STATUS_OFS    8'h50
`define LIMIT_COUNT_OFS     8'h51

// Reset values
`define TIMING_CFG_RST      8'h00
`define DETECT_CLASS_RST    8'h00
`define FOLDBACK_RST        4'h0
`define PORT_MODE_RST       8'h00

// Timing configuration field positions
`define LIMIT_SEL_LSB       6
`define INRUSH_SEL_LSB      4
`define OVERLOAD_SEL_LSB    2
`define DISC_DELAY_SEL_LSB  0

// Time base
`define CLK_PERIOD_NS       4
`define MS_NS               1000000
`define MS_CYCLES           (`MS_NS / `CLK_PERIOD_NS)

// Fault times in milliseconds
`define LIMIT_NOMINAL_MS    7'd60
`define LIMIT_SEL0_MS       7'd58
`define LIMIT_SEL1_MS       7'd15
`define LIMIT_SEL2_MS       7'd10
`define LIMIT_SEL3_MS       7'd6
`define INRUSH_SEL0_MS      7'd60
`define INRUSH_SEL1_MS      7'd30
`define INRUSH_SEL2_MS      7'd120
`define COOL_DOWN_MS        10'd1000
`define DECAY_DIVIDE        4'd8

`endif

// ==== shared/fault_timer_pkg.sv ====
package fault_timer_pkg;

	// Per-channel operating mode, two bits per channel
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_SEMI   = 2'b10,
		MODE_AUTO   = 2'b11
	} port_mode_t;

	// Cool-down sequencer
	typedef enum logic [0:0] {
		COOL_IDLE = 1'b0,
		COOL_RUN  = 1'b1
	} cool_state_t;

endpackage

// ==== verilog/channel_fault_counter.sv ====
`timescale 1ns/100ps
`include "fault_timer_params.svh"

module channel_fault_counter (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       ms_tick,
	input  wire logic       decay_tick,
	input  wire logic       channel_on,
	input  wire logic       limiting,
	input  wire logic       limit_sel_change,
	input  wire logic       turn_off_event,
	input  wire logic       cool_cancel,
	input  wire logic       restart_allowed,
	input  wire logic [6:0] limit_ms,
	input  wire logic [6:0] inrush_ms,
	output logic            limit_power_off,
	output logic            turn_on_inhibit,
	output logic            detect_restart,
	output logic            inrush_expired,
	output logic [6:0]      limit_count
);
	logic                          on_prev_q, on_prev_d;
	logic [6:0]                    inrush_cnt_q, inrush_cnt_d;
	logic [6:0]                    inrush_lim_q, inrush_lim_d;
	logic                          inrush_done_q, inrush_done_d;
	logic [6:0]                    lim_cnt_q, lim_cnt_d;
	logic                          trip_q, trip_d;
	logic                          restart_q, restart_d;
	logic [9:0]                    cool_cnt_q, cool_cnt_d;
	fault_timer_pkg::cool_state_t  cool_q, cool_d;
	logic                          trip;

	// Next state of inrush window, limit counter and cool-down
	always_comb begin
		on_prev_d     = channel_on;
		inrush_cnt_d  = inrush_cnt_q;
		inrush_lim_d  = inrush_lim_q;
		inrush_done_d = inrush_done_q;
		lim_cnt_d     = lim_cnt_q;
		cool_cnt_d    = cool_cnt_q;
		cool_d        = cool_q;
		restart_d     = 1'b0;
		trip          = 1'b0;
		// Inrush window, select latched at turn-on only
		if (channel_on && !on_prev_q) begin
			inrush_cnt_d  = 7'd0;
			inrush_lim_d  = inrush_ms;
			inrush_done_d = 1'b0;
		end else if (!channel_on) begin
			inrush_done_d = 1'b0;
		end else if (!inrush_done_q && ms_tick) begin
			inrush_cnt_d = inrush_cnt_q + 7'd1;
			if (inrush_cnt_d >= inrush_lim_q)
				inrush_done_d = 1'b1;
		end
		// Current-limit counter
		if (turn_off_event) begin
			lim_cnt_d = 7'd0;
		end else if (limit_sel_change) begin
			lim_cnt_d = 7'd0;
		end else if (channel_on && inrush_done_q && limiting) begin
			if (ms_tick) begin
				lim_cnt_d = lim_cnt_q + 7'd1;
				if (lim_cnt_d >= limit_ms) begin
					trip      = 1'b1;
					lim_cnt_d = 7'd0;
				end
			end
		end else if (channel_on && decay_tick && lim_cnt_q != 7'd0) begin
			lim_cnt_d = lim_cnt_q - 7'd1;
		end
		// Cool-down after a limit power-off
		case (cool_q)
			fault_timer_pkg::COOL_IDLE: begin
				if (trip) begin
					cool_d     = fault_timer_pkg::COOL_RUN;
					cool_cnt_d = `COOL_DOWN_MS;
				end
			end
			fault_timer_pkg::COOL_RUN: begin
				if (cool_cancel) begin
					cool_d = fault_timer_pkg::COOL_IDLE;
				end else if (ms_tick) begin
					cool_cnt_d = cool_cnt_q - 10'd1;
					if (cool_cnt_q == 10'd1) begin
						cool_d    = fault_timer_pkg::COOL_IDLE;
						restart_d = restart_allowed;
					end
				end
			end
			default: cool_d = fault_timer_pkg::COOL_IDLE;
		endcase
		trip_d = trip;
	end

	// State registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			on_prev_q     <= 1'b0;
			inrush_cnt_q  <= 7'd0;
			inrush_lim_q  <= `INRUSH_SEL0_MS;
			inrush_done_q <= 1'b0;
			lim_cnt_q     <= 7'd0;
			trip_q        <= 1'b0;
			restart_q     <= 1'b0;
			cool_cnt_q    <= 10'd0;
			cool_q        <= fault_timer_pkg::COOL_IDLE;
		end else begin
			on_prev_q     <= on_prev_d;
			inrush_cnt_q  <= inrush_cnt_d;
			inrush_lim_q  <= inrush_lim_d;
			inrush_done_q <= inrush_done_d;
			lim_cnt_q     <= lim_cnt_d;
			trip_q        <= trip_d;
			restart_q     <= restart_d;
			cool_cnt_q    <= cool_cnt_d;
			cool_q        <= cool_d;
		end
	end

	// Outputs straight from flip-flops
	assign limit_power_off = trip_q;
	assign turn_on_inhibit = (cool_q == fault_timer_pkg::COOL_RUN);
	assign detect_restart  = restart_q;
	assign inrush_expired  = inrush_done_q;
	assign limit_count     = lim_cnt_q;
endmodule

// ==== verilog/current_limit_fault_timer.sv ====
`timescale 1ns/100ps
`include "fault_timer_params.svh"

// Operation
// - One shared 8-bit timing register, offset 16h
// - Fields limit, inrush, overload, disconnect; reset zero
// - Foldback off: fixed nominal 60 ms timeout
// - Count up after inrush, while limiting
// - Counter reaching timeout powers channel off
// - Then one-second cool-down blocks turn-on
// - Below limit count down slower, floor zero
// - Turn-off events clear the limit counter
// - Limit select change restarts running counter
// - Semi-auto: cool-down end restarts detection
// - Reset command or off/manual cancels cool-down
// - Foldback on: timeout from select, 58/15/10/6 ms
// - Inrush select change applies next turn-on
module current_limit_fault_timer #(
	parameter int NUM_CH    = 4,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic [NUM_CH-1:0] channel_on,
	input  wire logic [NUM_CH-1:0] output_current_limit,
	input  wire logic [NUM_CH-1:0] power_enable_off_cmd,
	input  wire logic [NUM_CH-1:0] reset_cmd,
	input  wire logic [NUM_CH-1:0] dc_disconnect,
	input  wire logic [NUM_CH-1:0] fast_shutdown_input,
	output logic      [NUM_CH-1:0] limit_power_off,
	output logic      [NUM_CH-1:0] turn_on_inhibit,
	output logic      [NUM_CH-1:0] detect_restart,
	output logic      [NUM_CH-1:0] inrush_expired
);
	// Millisecond time base and decay divider
	logic [17:0] ms_div_q, ms_div_d;
	logic        ms_tick_q, ms_tick_d;
	logic [3:0]  decay_div_q, decay_div_d;
	logic        decay_tick_q, decay_tick_d;

	// Software visible registers
	logic [7:0]        timing_cfg_q, timing_cfg_d;
	logic [7:0]        detect_class_q, detect_class_d;
	logic [NUM_CH-1:0] foldback_q, foldback_d;
	logic [7:0]        port_mode_q, port_mode_d;
	logic [7:0]        rdata_q, rdata_d;

	// One-cycle command pulses from register writes
	logic              limit_sel_change_q, limit_sel_change_d;
	logic [NUM_CH-1:0] sw_reset_q, sw_reset_d;
	logic [NUM_CH-1:0] mode_cancel_q, mode_cancel_d;

	// Per-channel glue
	logic [NUM_CH-1:0] turn_off_event;
	logic [NUM_CH-1:0] cool_cancel;
	logic [NUM_CH-1:0] restart_allowed;
	logic [6:0]        limit_ms   [NUM_CH];
	logic [6:0]        limit_cnt  [NUM_CH];
	logic [6:0]        inrush_ms;

	// Timeout for the current-limit select, foldback per channel
	function automatic logic [6:0] limit_timeout_ms(
		input logic [1:0] sel,
		input logic       fb_en
	);
		logic [6:0] ms;
		ms = `LIMIT_NOMINAL_MS;
		if (fb_en) begin
			case (sel)
				2'b00:   ms = `LIMIT_SEL0_MS;
				2'b01:   ms = `LIMIT_SEL1_MS;
				2'b10:   ms = `LIMIT_SEL2_MS;
				2'b11:   ms = `LIMIT_SEL3_MS;
				default: ms = `LIMIT_SEL0_MS;
			endcase
		end
		return ms;
	endfunction

	// Inrush window for the inrush select, reserved code as 00
	function automatic logic [6:0] inrush_timeout_ms(
		input logic [1:0] sel
	);
		logic [6:0] ms;
		case (sel)
			2'b01:   ms = `INRUSH_SEL1_MS;
			2'b10:   ms = `INRUSH_SEL2_MS;
			default: ms = `INRUSH_SEL0_MS;
		endcase
		return ms;
	endfunction

	// Mode field of one channel
	function automatic fault_timer_pkg::port_mode_t mode_of(
		input logic [7:0] modes,
		input int         ch
	);
		logic [1:0] m;
		m = modes[2*ch +: 2];
		return fault_timer_pkg::port_mode_t'(m);
	endfunction

	// Divider producing the 1 ms tick and the slower decay tick
	always_comb begin
		ms_div_d     = ms_div_q + 18'd1;
		ms_tick_d    = 1'b0;
		decay_div_d  = decay_div_q;
		decay_tick_d = 1'b0;
		if (ms_div_q == 18'(MS_CYCLES - 1)) begin
			ms_div_d    = 18'd0;
			ms_tick_d   = 1'b1;
			decay_div_d = decay_div_q + 4'd1;
			if (decay_div_q == `DECAY_DIVIDE - 4'd1) begin
				decay_div_d  = 4'd0;
				decay_tick_d = 1'b1;
			end
		end
	end

	// Time base registers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ms_div_q     <= 18'd0;
			ms_tick_q    <= 1'b0;
			decay_div_q  <= 4'd0;
			decay_tick_q <= 1'b0;
		end else begin
			ms_div_q     <= ms_div_d;
			ms_tick_q    <= ms_tick_d;
			decay_div_q  <= decay_div_d;
			decay_tick_q <= decay_tick_d;
		end
	end

	// Register writes and the command pulses they raise
	always_comb begin
		timing_cfg_d       = timing_cfg_q;
		detect_class_d     = detect_class_q;
		foldback_d         = foldback_q;
		port_mode_d        = port_mode_q;
		limit_sel_change_d = 1'b0;
		sw_reset_d         = '0;
		mode_cancel_d      = '0;
		if (reg_wr) begin
			case (reg_addr)
				`TIMING_CFG_OFS: begin
					timing_cfg_d = reg_wdata;
					if (reg_wdata[`LIMIT_SEL_LSB +: 2] !=
					    timing_cfg_q[`LIMIT_SEL_LSB +: 2])
						limit_sel_change_d = 1'b1;
				end
				`DETECT_CLASS_OFS: detect_class_d = reg_wdata;
				`FOLDBACK_OFS:     foldback_d = reg_wdata[NUM_CH-1:0];
				`PORT_MODE_OFS: begin
					port_mode_d = reg_wdata;
					for (int i = 0; i < NUM_CH; i++) begin
						if (mode_of(reg_wdata, i) ==
						        fault_timer_pkg::MODE_OFF ||
						    mode_of(reg_wdata, i) ==
						        fault_timer_pkg::MODE_MANUAL)
							mode_cancel_d[i] = 1'b1;
					end
				end
				`PORT_RESET_OFS: sw_reset_d = reg_wdata[NUM_CH-1:0];
				default: ;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			timing_cfg_q       <= `TIMING_CFG_RST;
			detect_class_q     <= `DETECT_CLASS_RST;
			foldback_q         <= `FOLDBACK_RST;
			port_mode_q        <= `PORT_MODE_RST;
			limit_sel_change_q <= 1'b0;
			sw_reset_q         <= '0;
			mode_cancel_q      <= '0;
		end else begin
			timing_cfg_q       <= timing_cfg_d;
			detect_class_q     <= detect_class_d;
			foldback_q         <= foldback_d;
			port_mode_q        <= port_mode_d;
			limit_sel_change_q <= limit_sel_change_d;
			sw_reset_q         <= sw_reset_d;
			mode_cancel_q      <= mode_cancel_d;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`TIMING_CFG_OFS:   rdata_d = timing_cfg_q;
				`DETECT_CLASS_OFS: rdata_d = detect_class_q;
				`FOLDBACK_OFS:     rdata_d = 8'(foldback_q);
				`PORT_MODE_OFS:    rdata_d = port_mode_q;
				`FAULT_STATUS_OFS:
					rdata_d = {4'(inrush_expired), 4'(turn_on_inhibit)};
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (reg_addr == `LIMIT_COUNT_OFS + 8'(i))
							rdata_d = {1'b0, limit_cnt[i]};
					end
				end
			endcase
		end
	end

	// Read data stands for the one cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// Shared inrush window setting for every channel
	assign inrush_ms = inrush_timeout_ms(
		timing_cfg_q[`INRUSH_SEL_LSB +: 2]);

	// Per-channel event gathering from the shared settings
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			// Fast shutdown clears the counter but leaves cool-down
			turn_off_event[i] = power_enable_off_cmd[i] | reset_cmd[i] |
				sw_reset_q[i] | dc_disconnect[i] |
				fast_shutdown_input[i];
			cool_cancel[i] = reset_cmd[i] | sw_reset_q[i] |
				mode_cancel_q[i];
			restart_allowed[i] = detect_class_q[i] &&
				mode_of(port_mode_q, i) ==
				fault_timer_pkg::MODE_SEMI;
			limit_ms[i] = limit_timeout_ms(
				timing_cfg_q[`LIMIT_SEL_LSB +: 2],
				foldback_q[i]);
		end
	end

	// One independent counter set per channel
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		channel_fault_counter channel_fault_counter_i (
			.ref_clk          (ref_clk),
			.reset            (reset),
			.ms_tick          (ms_tick_q),
			.decay_tick       (decay_tick_q),
			.channel_on       (channel_on[g]),
			.limiting         (output_current_limit[g]),
			.limit_sel_change (limit_sel_change_q),
			.turn_off_event   (turn_off_event[g]),
			.cool_cancel      (cool_cancel[g]),
			.restart_allowed  (restart_allowed[g]),
			.limit_ms         (limit_ms[g]),
			.inrush_ms        (inrush_ms),
			.limit_power_off  (limit_power_off[g]),
			.turn_on_inhibit  (turn_on_inhibit[g]),
			.detect_restart   (detect_restart[g]),
			.inrush_expired   (inrush_expired[g]),
			.limit_count      (limit_cnt[g])
		);
	end
endmodule

// ==== test/fault_timer_properties.sv ====
`timescale 1ns/100ps
module fault_timer_checker #(
	parameter int NUM_CH    = 4,
	parameter int MS_CYCLES = 250000
) (
	input wire logic              ref_clk,
	input wire logic              reset,
	input wire logic [7:0]        reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic [NUM_CH-1:0] reset_cmd,
	input wire logic [NUM_CH-1:0] limit_power_off,
	input wire logic [NUM_CH-1:0] turn_on_inhibit,
	input wire logic [NUM_CH-1:0] detect_restart,
	input wire logic [NUM_CH-1:0] inrush_expired
);
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic       cxl_q;
	logic       cxl_d;
	int         inh_q;
	int         inh_d;
	// Register shadow, cancel history, cool-down length
	always_comb begin
		cfg_d = cfg_q;
		if (reg_wr && reg_addr == 8'h16) begin
			cfg_d = reg_wdata;
		end
		cxl_d = reg_wr | reset_cmd[0];
		inh_d = turn_on_inhibit[0] ? inh_q + 1 : 0;
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= 8'h00;
			cxl_q <= 1'b0;
			inh_q <= 0;
		end else begin
			cfg_q <= cfg_d;
			cxl_q <= cxl_d;
			inh_q <= inh_d;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	read_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray data");
	cfg_read_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 8'h16 |-> reg_rdata == cfg_q)
		else $error("config readback");
	trip_pulse_a: assert property (
		limit_power_off[0] |=> !limit_power_off[0]) else $error("trip width");
	trip_cause_a: assert property (
		limit_power_off[0] |-> $past(inrush_expired[0]))
		else $error("trip in inrush");
	cool_start_a: assert property (
		limit_power_off[0] |-> turn_on_inhibit[0]) else $error("no cool-down");
	cool_short_a: assert property (
		$fell(turn_on_inhibit[0]) && !cxl_q && !$past(cxl_q)
		|-> inh_q >= 999 * MS_CYCLES) else $error("cool-down short");
	cool_long_a: assert property (
		inh_q <= 1000 * MS_CYCLES + 2) else $error("cool-down long");
	restart_pulse_a: assert property (
		detect_restart[0] |=> !detect_restart[0]) else $error("restart width");
	restart_end_a: assert property (
		detect_restart[0] |-> !turn_on_inhibit[0]) else $error("early restart");
	cancel_cmd_a: assert property (
		reset_cmd[0] |-> ##[1:2] !turn_on_inhibit[0]) else $error("no cancel");
	cover property (limit_power_off[0]);
	cover property (detect_restart[0]);
	cover property ($fell(turn_on_inhibit[0]) && cxl_q);
endmodule

bind current_limit_fault_timer fault_timer_checker #(
	.NUM_CH    (NUM_CH),
	.MS_CYCLES (MS_CYCLES)
) fault_timer_checker_i (
	.ref_clk         (ref_clk),
	.reset           (reset),
	.reg_addr        (reg_addr),
	.reg_wdata       (reg_wdata),
	.reg_wr          (reg_wr),
	.reg_rd          (reg_rd),
	.reg_rdata       (reg_rdata),
	.reset_cmd       (reset_cmd),
	.limit_power_off (limit_power_off),
	.turn_on_inhibit (turn_on_inhibit),
	.detect_restart  (detect_restart),
	.inrush_expired  (inrush_expired)
);

// ==== test/channel_switch_model.sv ====
`timescale 1ns/100ps
module channel_switch_model (
	input wire logic  ref_clk,
	input wire logic  reset,
	input wire logic  [3:0] power_req,
	input wire logic  [3:0] load_req,
	input wire logic  [3:0] limit_power_off,
	input wire logic  [3:0] turn_on_inhibit,
	output logic      [3:0] channel_on,
	output logic      [3:0] output_current_limit
);
	logic [3:0] on_d;
	// Switch closes on request, opens on a trip, stays open in cool-down
	always_comb begin
		on_d = power_req & ~turn_on_inhibit & ~limit_power_off;
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			channel_on <= 4'h0;
		end else begin
			channel_on <= on_d;
		end
	end
	// Load hits the limit only while powered
	assign output_current_limit = load_req & channel_on;
endmodule

// ==== test/current_limit_fault_timer_tb.sv ====
`timescale 1ns/100ps
module current_limit_fault_timer_tb;
	localparam int MS = 4;
	logic        ref_clk;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [3:0]  power_req;
	logic [3:0]  load_req;
	logic [3:0]  channel_on;
	logic [3:0]  over_lim;
	logic [3:0]  pe_off;
	logic [3:0]  rcmd;
	logic [3:0]  dcd;
	logic [3:0]  fsd;
	logic [3:0]  lpo;
	logic [3:0]  inh;
	logic [3:0]  drs;
	logic [3:0]  inx;
	logic [7:0]  v;
	logic [7:0]  w;
	logic [23:0] rows [6];
	int          limit_fault_time_sel [4];
	int          fail_count;
	int          comparisons;
	int          cyc;
	int          n;

	current_limit_fault_timer #(.MS_CYCLES(MS)) current_limit_fault_timer_i (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .channel_on(channel_on),
		.output_current_limit(over_lim), .power_enable_off_cmd(pe_off),
		.reset_cmd(rcmd), .dc_disconnect(dcd), .fast_shutdown_input(fsd),
		.limit_power_off(lpo), .turn_on_inhibit(inh),
		.detect_restart(drs), .inrush_expired(inx));
	channel_switch_model channel_switch_model_i (
		.ref_clk(ref_clk), .reset(reset), .power_req(power_req),
		.load_req(load_req), .limit_power_off(lpo), .turn_on_inhibit(inh),
		.channel_on(channel_on), .output_current_limit(over_lim));

	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Register bus cycles, one idle edge after each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
		@(posedge ref_clk);
	endtask
	// Power a loaded channel and time it to the trip
	task automatic trip(input int ch, input int ms);
		power_req[ch] <= 1'b1;
		load_req[ch] <= 1'b1;
		n = 0;
		while (lpo[ch] !== 1'b1 && n < 9999) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= (ms - 1) * MS && n <= (ms + 1) * MS + 4, 1);
		chk(inh[ch], 1'b1);
		@(posedge ref_clk);
		power_req[ch] <= 1'b0;
		load_req[ch] <= 1'b0;
	endtask
	// Limit channel 0 for a while past inrush, then read its count
	task automatic lim(input int ms);
		power_req[0] <= 1'b1;
		load_req[0] <= 1'b1;
		repeat ((31 + ms) * MS) @(posedge ref_clk);
		load_req[0] <= 1'b0;
		rd(8'h51, v);
	endtask

	initial begin
		{reset, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h40000;
		{power_req, load_req, pe_off, rcmd, dcd, fsd} = 24'h0;
		rows = '{24'h16c0c0, 24'h140505, 24'h400e0e, 24'h120202,
			24'h33ff00, 24'h161010};
		limit_fault_time_sel = '{58, 15, 10, 6};
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(8'h16, v);
		chk(v, 8'h00);
		$display("done: reset");
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], v);
			chk(v, rows[i][7:0]);
		end
		$display("done: registers");
		for (int c = 0; c < 4; c++) begin
			wr(8'h16, {c[1:0], 6'h10});
			trip(1, 30 + limit_fault_time_sel[c]);
			rcmd[1] <= 1'b1;
			@(posedge ref_clk);
			rcmd[1] <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk(inh[1], 1'b0);
		end
		// Status readback mid cool-down, then port reset register cancel
		trip(1, 36);
		repeat (2) @(posedge ref_clk);
		rd(8'h50, v);
		chk(v, 8'h02);
		wr(8'h1a, 8'h02);
		@(posedge ref_clk);
		chk(inh[1], 1'b0);
		// Manual mode on channel 1 cancels its cool-down too
		trip(1, 36);
		wr(8'h12, 8'h06);
		@(posedge ref_clk);
		chk(inh[1], 1'b0);
		trip(0, 90);
		n = 0;
		while (drs[0] !== 1'b1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 998 * MS && n <= 1001 * MS, 1);
		@(posedge ref_clk);
		trip(0, 90);
		wr(8'h12, 8'h00);
		@(posedge ref_clk);
		chk(inh[0], 1'b0);
		wr(8'h12, 8'h02);
		n = 0;
		repeat (1002 * MS) begin
			@(negedge ref_clk);
			n += (drs[0] === 1'b1);
		end
		chk(n, 0);
		$display("done: trips");
		@(posedge ref_clk);
		lim(20);
		chk(v >= 19 && v <= 22, 1);
		w = v;
		repeat (80 * MS) @(posedge ref_clk);
		rd(8'h51, v);
		chk(v >= w - 11 && v <= w - 9, 1);
		repeat (200 * MS) @(posedge ref_clk);
		rd(8'h51, v);
		chk(v, 8'h00);
		power_req[0] <= 1'b0;
		// Each turn-off input and a limit select rewrite clear the count
		for (int k = 0; k < 5; k++) begin
			repeat (3) @(posedge ref_clk);
			lim(20);
			case (k)
				0: pe_off[0] <= 1'b1;
				1: rcmd[0] <= 1'b1;
				2: dcd[0] <= 1'b1;
				3: fsd[0] <= 1'b1;
				default: wr(8'h16, 8'h50);
			endcase
			@(posedge ref_clk);
			{pe_off, rcmd, dcd, fsd} <= 16'h0;
			power_req[0] <= 1'b0;
			repeat (3) @(posedge ref_clk);
			rd(8'h51, v);
			chk(v, 8'h00);
		end
		$display("done: counter");
		power_req[0] <= 1'b1;
		repeat (10 * MS) @(posedge ref_clk);
		wr(8'h16, 8'h60);
		n = 0;
		while (inx[0] !== 1'b1 && n < 999) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 18 * MS && n <= 21 * MS, 1);
		@(posedge ref_clk);
		power_req[0] <= 1'b0;
		rd(8'h53, v);
		chk(v, 8'h00);
		$display("done: inrush");
		conclude();
	end
endmodule
